// ### hw/spq_core.sv
`timescale 1ns/1ns
// Behaviour
// - In slave mode the disable command is ignored and only software reset stops the block.
// - Mixed divisors of one and not one with polarity 1 and phase 0 give one extra clock pulse.
// - With cs 0 held after transfer and mode fault detection on, no master transfer ever starts.
// - While disabled, data writes are dropped and neither they nor disable touch the empty flag.
// - Words the DMA channel writes while disabled are lost.
module spq_core (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic software_reset_bit,
	input wire logic enable_cmd,
	input wire logic disable_cmd,
	input wire logic master_mode,
	input wire logic mode_fault_disable,
	input wire logic [spq_pkg::CS_W-1:0] cs_select,
	input wire logic [spq_pkg::NUM_CS*spq_pkg::DIV_W-1:0] serial_clock_divisor,
	input wire logic clock_polarity_bit,
	input wire logic clock_phase_bit,
	input wire logic [spq_pkg::NUM_CS-1:0] cs_hold_after_transfer,
	input wire logic tx_write,
	input wire logic [spq_pkg::DATA_W-1:0] tx_data_register,
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic ss_b_in,
	output logic enabled,
	output logic tx_empty_flag,
	output logic rx_full,
	output logic [spq_pkg::DATA_W-1:0] rx_data,
	output logic tx_dropped,
	output logic sck_out,
	output logic sck_oe,
	output logic mosi_out,
	output logic miso_out,
	output logic miso_oe,
	output logic [spq_pkg::NUM_CS-1:0] cs_b_out
);
	spq_pkg::spq_state_e st_q, st_d;
	logic en_q;
	logic empty_q;
	logic [spq_pkg::DATA_W-1:0] hold_q;
	logic [spq_pkg::DATA_W-1:0] shift_q;
	logic [spq_pkg::DATA_W-1:0] rx_q;
	logic rx_full_q;
	logic drop_q;
	logic [spq_pkg::BIT_CNT_W-1:0] bit_q;
	logic [spq_pkg::DIV_W-1:0] div_q;
	logic sck_q;
	logic extra_q;
	logic [spq_pkg::NUM_CS-1:0] cs_q;
	logic [spq_pkg::CS_W-1:0] cur_cs_q;
	logic sck_s, mosi_s, ss_b_s, sck_s_prev_q;

	// Divisor of one chip select, shared by several decodes
	function automatic logic [spq_pkg::DIV_W-1:0] div_of(
		input logic [spq_pkg::NUM_CS*spq_pkg::DIV_W-1:0] all,
		input logic [spq_pkg::CS_W-1:0] idx);
		div_of = all[idx*spq_pkg::DIV_W +: spq_pkg::DIV_W];
	endfunction : div_of

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	spq_sync u_sck (.clk(clk), .rst_b(rst_b), .pin(sck_in), .level(sck_s));
	spq_sync u_mosi (.clk(clk), .rst_b(rst_b), .pin(mosi_in), .level(mosi_s));
	spq_sync u_ss (.clk(clk), .rst_b(rst_b), .pin(ss_b_in), .level(ss_b_s));

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic any_one, any_other, mixed_div, hang, wr_ok, start, slave_sel;
	logic half_tick, sample_edge, slv_edge;
	always_comb begin
		any_one = 1'b0;
		any_other = 1'b0;
		for (int i = 0; i < spq_pkg::NUM_CS; i++) begin
			if (div_of(serial_clock_divisor, i[spq_pkg::CS_W-1:0]) == spq_pkg::DIV_ONE) begin
				any_one = 1'b1;
			end else begin
				any_other = 1'b1;
			end
		end
	end
	// Flawed combination produces one surplus clock edge pair
	assign mixed_div = any_one && any_other && clock_polarity_bit && !clock_phase_bit;
	// Hold-after-transfer on cs 0 with fault detection on deadlocks start
	assign hang = cs_hold_after_transfer[0] && !mode_fault_disable;
	// Writes while disabled are filtered; the DMA keeps writing and loses data
	assign wr_ok = tx_write && en_q;
	assign start = master_mode && en_q && !empty_q && !hang && (st_q == spq_pkg::SPQ_IDLE);
	assign half_tick = (div_q == spq_pkg::DIV_CNT_RST);
	assign sample_edge = half_tick && (sck_q == clock_polarity_bit);
	assign slave_sel = !master_mode && en_q && !ss_b_s;
	assign slv_edge = slave_sel && (sck_s != sck_s_prev_q) && (sck_s != clock_polarity_bit);

	// ----------------------------------------------------------------
	// Master sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			spq_pkg::SPQ_IDLE: if (start) st_d = spq_pkg::SPQ_LEAD;
			spq_pkg::SPQ_LEAD: if (half_tick) st_d = spq_pkg::SPQ_SHIFT;
			spq_pkg::SPQ_SHIFT: begin
				if (sample_edge && bit_q == spq_pkg::LAST_BIT && !extra_q) st_d = spq_pkg::SPQ_DONE;
			end
			spq_pkg::SPQ_DONE: if (half_tick) st_d = spq_pkg::SPQ_IDLE;
		endcase
	end

	// Enable state: in slave mode a disable is ignored
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_q <= 1'b0;
		end else if (software_reset_bit) begin
			en_q <= 1'b0;
		end else if (enable_cmd) begin
			en_q <= 1'b1;
		end else if (disable_cmd && master_mode) begin
			en_q <= 1'b0;
		end
	end

	// Empty flag: a load into the shifter sets it, an accepted write clears it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			empty_q <= 1'b1;
			hold_q <= spq_pkg::DATA_RST;
			drop_q <= 1'b0;
		end else if (software_reset_bit) begin
			empty_q <= 1'b1;
			drop_q <= 1'b0;
		end else begin
			drop_q <= tx_write && !en_q;
			if (wr_ok) begin
				empty_q <= 1'b0;
				hold_q <= tx_data_register;
			end else if (start || (slave_sel && st_q == spq_pkg::SPQ_IDLE && !empty_q)) begin
				empty_q <= 1'b1;
			end
		end
	end

	// Shift, clock and chip-select datapath
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= spq_pkg::SPQ_IDLE;
			shift_q <= spq_pkg::DATA_RST;
			rx_q <= spq_pkg::DATA_RST;
			rx_full_q <= 1'b0;
			bit_q <= '0;
			div_q <= spq_pkg::DIV_CNT_RST;
			sck_q <= 1'b0;
			extra_q <= 1'b0;
			cs_q <= '1;
			cur_cs_q <= spq_pkg::CS_ZERO;
			sck_s_prev_q <= 1'b0;
		end else if (software_reset_bit) begin
			st_q <= spq_pkg::SPQ_IDLE;
			rx_full_q <= 1'b0;
			bit_q <= '0;
			sck_q <= clock_polarity_bit;
			cs_q <= '1;
		end else begin
			st_q <= st_d;
			sck_s_prev_q <= sck_s;
			div_q <= (half_tick || st_q == spq_pkg::SPQ_IDLE) ?
				div_of(serial_clock_divisor, cur_cs_q) - spq_pkg::DIV_ONE :
				div_q - spq_pkg::DIV_ONE;
			if (st_q == spq_pkg::SPQ_IDLE) begin
				sck_q <= clock_polarity_bit;
				if (start) begin
					shift_q <= hold_q;
					bit_q <= '0;
					cur_cs_q <= cs_select;
					cs_q <= ~(4'b0001 << cs_select);
					extra_q <= mixed_div;
				end else if (!cs_hold_after_transfer[cur_cs_q]) begin
					cs_q <= '1;
				end
			end
			if (st_q == spq_pkg::SPQ_SHIFT && half_tick) begin
				sck_q <= ~sck_q;
				if (sample_edge) begin
					if (extra_q) begin
						extra_q <= 1'b0;
					end else begin
						shift_q <= {shift_q[spq_pkg::DATA_W-2:0], mosi_s};
						bit_q <= bit_q + 1'b1;
						if (bit_q == spq_pkg::LAST_BIT) begin
							rx_q <= {shift_q[spq_pkg::DATA_W-2:0], mosi_s};
							rx_full_q <= 1'b1;
						end
					end
				end
			end
			// Slave receive keeps running after a disable request
			if (slv_edge) begin
				shift_q <= {shift_q[spq_pkg::DATA_W-2:0], mosi_s};
				bit_q <= bit_q + 1'b1;
				if (bit_q == spq_pkg::LAST_BIT) begin
					rx_q <= {shift_q[spq_pkg::DATA_W-2:0], mosi_s};
					rx_full_q <= 1'b1;
					bit_q <= '0;
				end
			end else if (slave_sel && st_q == spq_pkg::SPQ_IDLE && !empty_q && bit_q == '0) begin
				shift_q <= hold_q;
			end
		end
	end

	assign enabled = en_q;
	assign tx_empty_flag = empty_q;
	assign rx_full = rx_full_q;
	assign rx_data = rx_q;
	assign tx_dropped = drop_q;
	assign sck_out = sck_q;
	assign sck_oe = master_mode && en_q;
	assign mosi_out = shift_q[spq_pkg::DATA_W-1];
	assign miso_out = shift_q[spq_pkg::DATA_W-1];
	assign miso_oe = slave_sel;
	assign cs_b_out = cs_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	hang_no_start_a: assert property (@(posedge clk) disable iff (!rst_b)
		(hang && st_q == spq_pkg::SPQ_IDLE && !software_reset_bit) |=>
		(st_q == spq_pkg::SPQ_IDLE)) else $error("transfer started while hung");
	slave_keeps_en_a: assert property (@(posedge clk) disable iff (!rst_b)
		(en_q && !master_mode && !software_reset_bit) |=> en_q) else $error("slave disabled");
	off_write_keeps_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!en_q && !software_reset_bit) |=> $stable(empty_q)) else $error("empty flag moved");
	write_clears_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_ok && !software_reset_bit) |=> !empty_q) else $error("write did not clear empty");
	drop_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		(tx_write && !en_q && !software_reset_bit) |=> drop_q) else $error("lost write unflagged");
	reset_stops_a: assert property (@(posedge clk) disable iff (!rst_b)
		software_reset_bit |=> (!en_q && empty_q)) else $error("soft reset ignored");
	extra_arm_a: assert property (@(posedge clk) disable iff (!rst_b)
		(start && !software_reset_bit) |=> (extra_q == $past(mixed_div))) else $error("extra pulse");
endmodule : spq_core

// ### hw/spq_pkg.sv
package spq_pkg;
	// ----------------------------------------------------------------
	// Widths and constants
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int DIV_W = 8;
	localparam int NUM_CS = 4;
	localparam int CS_W = 2;
	localparam int BIT_CNT_W = 4;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
	localparam logic [CS_W-1:0] CS_ZERO = 2'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [DIV_W-1:0] DIV_CNT_RST = 8'h00;

	// Master transfer states, Gray coded along idle -> lead -> shift -> done
	typedef enum logic [1:0] {
		SPQ_IDLE = 2'b00,
		SPQ_LEAD = 2'b01,
		SPQ_SHIFT = 2'b11,
		SPQ_DONE = 2'b10
	} spq_state_e;
endpackage : spq_pkg

// ### hw/spq_sync.sv
`timescale 1ns/1ns
// Three-stage pin synchroniser; a change counts once stages two and three agree
module spq_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	output logic level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;

	// ----------------------------------------------------------------
	// Capture chain
	// ----------------------------------------------------------------
	// Only s2 reads s1, so metastability never reaches logic
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	assign level = lvl_q;
endmodule : spq_sync

// ### dv/spq_peer.sv
`timescale 1ns/1ns
// ----------------------------------------
// Serial peer: counts master clock edges, acts as master to a slave
// ----------------------------------------
module spq_peer (
	input wire logic clk,
	input wire logic sck_out,
	input wire logic [3:0] cs_b_out,
	output logic sck_in,
	output logic mosi_in,
	output logic ss_b_in
);
	int edges;
	logic sck_q;
	logic [3:0] cs_q;
	// Idle frame: clock stands still, select deasserted by pull-up
	initial begin
		edges = 0;
		sck_q = 1'b0;
		cs_q = 4'hf;
		{sck_in, mosi_in, ss_b_in} = 3'h1;
	end
	// Edges count inside a frame and on the edge that closes it, where the
	// clock returns to idle together with the select; idle changes are not pulses
	always @(posedge clk) begin
		sck_q <= sck_out;
		cs_q <= cs_b_out;
		if ((cs_b_out !== 4'hf || cs_q !== 4'hf) && sck_q !== sck_out) edges <= edges + 1;
	end
	// Data changes mid low phase, so either sampling edge sees it settled
	task automatic send(input logic [7:0] b);
		ss_b_in = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi_in = b[i];
			repeat (4) @(posedge clk);
			#1 sck_in = 1'b1;
			repeat (8) @(posedge clk);
			#1 sck_in = 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (8) @(posedge clk);
		#1 mosi_in = ~b[0]; // Released line shows the inverse
		ss_b_in = 1'b1;
	endtask : send
endmodule : spq_peer

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic clk, rst_b, swr, en_c, dis_c, mm, mfd, pol, pha, txw;
	logic [1:0] css;
	logic [31:0] div;
	logic [3:0] hold, cs_b;
	logic [7:0] txd, rx_data;
	logic enabled, empty, rx_full, tx_dropped, sck_out, sck_oe, mosi_out, miso_out, miso_oe;
	logic sck_in, mosi_in, ss_b_in;
	int err_total = 0;
	int comparisons = 0;
	spq_core spq_core_i (.clk(clk), .rst_b(rst_b), .software_reset_bit(swr), .enable_cmd(en_c),
		.disable_cmd(dis_c), .master_mode(mm), .mode_fault_disable(mfd), .cs_select(css),
		.serial_clock_divisor(div), .clock_polarity_bit(pol), .clock_phase_bit(pha),
		.cs_hold_after_transfer(hold), .tx_write(txw), .tx_data_register(txd), .sck_in(sck_in),
		.mosi_in(mosi_in), .ss_b_in(ss_b_in), .enabled(enabled), .tx_empty_flag(empty),
		.rx_full(rx_full), .rx_data(rx_data), .tx_dropped(tx_dropped), .sck_out(sck_out),
		.sck_oe(sck_oe), .mosi_out(mosi_out), .miso_out(miso_out), .miso_oe(miso_oe),
		.cs_b_out(cs_b));
	spq_peer spq_peer_i (.clk(clk), .sck_out(sck_out), .cs_b_out(cs_b), .sck_in(sck_in),
		.mosi_in(mosi_in), .ss_b_in(ss_b_in));
	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// Command pulse: 0 software reset, 1 enable, 2 disable
	// An edge passes first, so back-to-back commands never restrike in one step
	task automatic cmd(input int k);
		wt(1);
		{swr, en_c, dis_c} = 3'(4 >> k);
		wt(1);
		{swr, en_c, dis_c} = 3'h0;
	endtask : cmd
	task automatic write(input logic [7:0] d);
		txd = d;
		txw = 1'b1;
		wt(1);
		txw = 1'b0;
	endtask : write
	// Bounded wait; a hang shows up in the compare that follows
	task automatic wait_cs(input logic [3:0] v);
		for (int i = 0; i < 600 && cs_b !== v; i++) wt(1);
	endtask : wait_cs
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// A DMA-like burst of writes while disabled: every word is lost
	task automatic t_disabled;
		int n;
		n = 0;
		txd = 8'hc3;
		txw = 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (i == 3) txw = 1'b0;
			wt(1);
			n += (tx_dropped === 1'b1);
			check("empty", empty, 1);
		end
		check("dropped", n, 3);
		check("cs", cs_b, 4'hf);
	endtask : t_disabled
	task automatic t_xfer(input logic [31:0] d, input int pulses);
		int e0;
		div = d;
		e0 = spq_peer_i.edges;
		write(8'ha5);
		// Empty stands low for one cycle only, before the word loads
		check("empty", empty, 0);
		check("sck_oe", sck_oe, 1);
		wait_cs(4'he);
		wait_cs(4'hf);
		// The closing clock edge reaches the peer's count one edge later
		wt(2);
		check("pulses", (spq_peer_i.edges - e0) / 2, pulses);
	endtask : t_xfer
	// Held select with fault detection on never starts; fault disable frees it
	task automatic t_hang;
		logic e;
		{div, hold, mfd} = {32'h0101_0101, 4'h1, 1'b0};
		write(8'h3c);
		wt(30);
		check("cs", cs_b, 4'hf);
		check("empty", empty, 0);
		// Disable with a word pending: flag keeps its low level, writes are lost
		cmd(2);
		check("enabled", enabled, 0);
		check("empty", empty, 0);
		write(8'h55);
		check("dropped", tx_dropped, 1);
		check("empty", empty, 0);
		cmd(1);
		mfd = 1'b1;
		wait_cs(4'he);
		check("cs", cs_b, 4'he);
		wt(40);
		e = empty;
		cmd(2);
		wt(1);
		check("enabled", enabled, 0);
		check("empty", empty, e);
		cmd(0);
		hold = 4'h0;
	endtask : t_hang
	task automatic t_slave;
		{mm, pol, pha} = 3'h1;
		cmd(1);
		cmd(2);
		wt(1);
		check("enabled", enabled, 1);
		spq_peer_i.send(8'h96);
		wt(6);
		check("rx", rx_data, 8'h96);
		check("full", rx_full, 1);
		check("miso", miso_out, 1);
		check("mosi", mosi_out, 1);
		check("miso_oe", miso_oe, 0);
		check("sck_oe", sck_oe, 0);
		cmd(0);
		wt(1);
		check("enabled", enabled, 0);
		check("empty", empty, 1);
	endtask : t_slave
	// ----------------------------------------
	// Clock, reset, sequence and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst_b, swr, en_c, dis_c, mfd, pol, pha, txw} = 8'h00;
		{css, hold, txd, div, mm} = {14'h0000, 32'h0101_0101, 1'b1};
		wt(6);
		rst_b = 1'b1;
		check("empty", empty, 1);
		t_disabled;
		cmd(1);
		pol = 1'b1;
		t_xfer(32'h0101_0101, 8);
		t_xfer(32'h0202_0202, 8);
		t_xfer(32'h0000_0201, 9);
		pol = 1'b0;
		t_xfer(32'h0000_0201, 8);
		cmd(1);
		t_hang;
		t_slave;
		print_verdict;
	end
	// Whole run is a few hundred cycles; this is far past it
	initial begin
		#400000;
		err_total++;
		print_verdict;
	end
endmodule : testbench
